//--- core/gr_consts.svh
// Constants for the gamma reference serial programming port.
// Function
// - Mode strap high standard, low register mode
// - Answer address 74 or 75 by strap
// - Curve select picks bank driving outputs
// - Separate 8-bit code per each of 14 outputs
// - Channels 1-7 upper, 8-14 lower bank
// - Operate at bus clock up to 400kHz
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Busy from start, free after stop interval
// - Data changes only while clock low
// - Every byte is exactly eight bits
// - Unlimited bytes between start and stop
// - Bytes shift most significant bit first
// - Receiver pulls data low on ninth clock
// - Upper six address bits fixed 111010
// - Bit after address: 0 write, 1 read
// - Control bit one write bank, two read bank
`ifndef GR_CONSTS_SVH
`define GR_CONSTS_SVH
`define GR_ADDR_HIGH      6'h3a
`define GR_CHANNELS       14
`define GR_HALF           7
`define GR_LAST_CHAN      4'hd
`define GR_CTRL_WBANK     1
`define GR_CTRL_RBANK     2
`define GR_BIT_ACK        4'h8
`define GR_BIT_ACKCLK     4'h9
`define GR_CLK_NS         50
`define GR_BUS_FREE_NS    1300
`define GR_BUS_FREE_CYC   ((`GR_BUS_FREE_NS + `GR_CLK_NS - 1) / `GR_CLK_NS)
`endif

//--- core/gr_pkg.sv
// Types for the gamma reference serial programming port.
package gr_pkg;
  typedef logic [7:0]  gr_code_type;
  typedef logic [55:0] gr_half_type;
  typedef logic [3:0]  gr_chan_type;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_CTRL   = 3'h3,
    ST_PTR    = 3'h2,
    ST_WDATA  = 3'h6,
    ST_RDATA  = 3'h7,
    ST_IGNORE = 3'h5
  } gr_state_type;
endpackage : gr_pkg

//--- core/gr_i2c_port.sv
// Serial programming port with two code banks for the gamma reference generator.
`timescale 1ns/100ps
`default_nettype none
`include "gr_consts.svh"
module gr_i2c_port (
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  output logic                sda_out,
  output logic                sda_oe_n,
  input  wire logic           mode_strap_pin,
  input  wire logic           address_lsb_strap,
  input  wire logic           curve_select,
  input  wire logic           load_ready,
  output gr_pkg::gr_half_type upper_bank_outputs,
  output gr_pkg::gr_half_type lower_bank_outputs,
  output logic                bus_busy
);
  import gr_pkg::*;

  logic [2:0]   scl_sync_ff;
  logic [2:0]   sda_sync_ff;
  logic [2:0]   mode_sync_ff;
  logic [2:0]   alsb_sync_ff;
  logic [2:0]   csel_sync_ff;
  logic         scl_f_ff;
  logic         sda_f_ff;
  logic         mode_f_ff;
  logic         alsb_f_ff;
  logic         csel_f_ff;
  logic         scl_prev_ff;
  logic         sda_prev_ff;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_seen;
  logic         stop_seen;
  gr_state_type state_ff;
  logic [3:0]   bitcnt_ff;
  gr_code_type  shift_ff;
  gr_code_type  tx_ff;
  logic         sda_low_ff;
  logic         wbank_ff;
  logic         rbank_ff;
  gr_chan_type  ptr_ff;
  logic         byte_done;
  logic         push;
  logic         pop;
  logic         in_ready;
  logic [12:0]  buf_ff [2];
  logic         buf_wr_ff;
  logic         buf_rd_ff;
  logic [1:0]   buf_cnt_ff;
  logic [12:0]  buf_head;
  gr_code_type  bank_ff [2][`GR_CHANNELS];
  gr_code_type  code_ff [`GR_CHANNELS];
  logic [4:0]   free_cnt_ff;
  logic         bus_free_ff;

  // Pins cross into the core clock; a level only counts once the last two stages agree.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_sync_ff  <= 3'h7;
      sda_sync_ff  <= 3'h7;
      mode_sync_ff <= 3'h7;
      alsb_sync_ff <= 3'h0;
      csel_sync_ff <= 3'h0;
    end else if (clk_en) begin
      scl_sync_ff  <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff  <= {sda_sync_ff[1:0], sda_in};
      mode_sync_ff <= {mode_sync_ff[1:0], mode_strap_pin};
      alsb_sync_ff <= {alsb_sync_ff[1:0], address_lsb_strap};
      csel_sync_ff <= {csel_sync_ff[1:0], curve_select};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_f_ff  <= 1'b1;
      sda_f_ff  <= 1'b1;
      mode_f_ff <= 1'b1;
      alsb_f_ff <= 1'b0;
      csel_f_ff <= 1'b0;
    end else if (clk_en) begin
      if (scl_sync_ff[1] == scl_sync_ff[2])
        scl_f_ff <= scl_sync_ff[2];
      if (sda_sync_ff[1] == sda_sync_ff[2])
        sda_f_ff <= sda_sync_ff[2];
      if (mode_sync_ff[1] == mode_sync_ff[2])
        mode_f_ff <= mode_sync_ff[2];
      if (alsb_sync_ff[1] == alsb_sync_ff[2])
        alsb_f_ff <= alsb_sync_ff[2];
      if (csel_sync_ff[1] == csel_sync_ff[2])
        csel_f_ff <= csel_sync_ff[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else if (clk_en) begin
      scl_prev_ff <= scl_f_ff;
      sda_prev_ff <= sda_f_ff;
    end
  end

  // The filter is a few cycles against a 2.5 us bit time, ample headroom at 400 kHz.
  assign scl_rise   = clk_en & scl_f_ff & ~scl_prev_ff;
  assign scl_fall   = clk_en & ~scl_f_ff & scl_prev_ff;
  assign start_seen = clk_en & scl_f_ff & scl_prev_ff & sda_prev_ff & ~sda_f_ff;
  assign stop_seen  = clk_en & scl_f_ff & scl_prev_ff & ~sda_prev_ff & sda_f_ff;
  assign byte_done  = scl_fall & (bitcnt_ff == `GR_BIT_ACK);
  assign in_ready   = (buf_cnt_ff != 2'h2);
  assign push       = byte_done & (state_ff == ST_WDATA) & in_ready &
                      (ptr_ff <= `GR_LAST_CHAN);
  assign pop        = clk_en & (buf_cnt_ff != 2'h0) & load_ready;

  // Bits are counted on rising clock edges; the ninth clock is the acknowledge slot.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitcnt_ff <= 4'h0;
      shift_ff  <= 8'h00;
    end else if (start_seen || stop_seen) begin
      bitcnt_ff <= 4'h0;
    end else if (scl_rise && state_ff != ST_IDLE && state_ff != ST_IGNORE) begin
      if (bitcnt_ff < `GR_BIT_ACK)
        shift_ff <= {shift_ff[6:0], sda_f_ff};
      if (bitcnt_ff != `GR_BIT_ACKCLK)
        bitcnt_ff <= bitcnt_ff + 4'h1;
    end else if (scl_fall && bitcnt_ff == `GR_BIT_ACKCLK) begin
      bitcnt_ff <= 4'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      wbank_ff <= 1'b0;
      rbank_ff <= 1'b0;
      ptr_ff   <= 4'h0;
    end else if (stop_seen) begin
      state_ff <= ST_IDLE;
    end else if (start_seen) begin
      state_ff <= ST_ADDR;
    end else if (byte_done) begin
      unique case (state_ff)
        ST_ADDR: begin
          if (shift_ff[7:1] == {`GR_ADDR_HIGH, alsb_f_ff}) begin
            state_ff <= shift_ff[0] ? ST_RDATA : ST_CTRL;
            if (mode_f_ff)
              ptr_ff <= 4'h0;
          end else begin
            state_ff <= ST_IGNORE;
          end
        end
        ST_CTRL: begin
          wbank_ff <= shift_ff[`GR_CTRL_WBANK];
          rbank_ff <= shift_ff[`GR_CTRL_RBANK];
          ptr_ff   <= 4'h0;
          state_ff <= mode_f_ff ? ST_WDATA : ST_PTR;
        end
        ST_PTR: begin
          ptr_ff   <= (shift_ff[3:0] > `GR_LAST_CHAN) ? 4'h0 : shift_ff[3:0];
          state_ff <= ST_WDATA;
        end
        ST_WDATA: begin
          if (push)
            ptr_ff <= ptr_ff + 4'h1;
        end
        ST_RDATA, ST_IDLE, ST_IGNORE: begin
        end
        default: state_ff <= ST_IDLE;
      endcase
    end else if (scl_rise && bitcnt_ff == `GR_BIT_ACK && state_ff == ST_RDATA) begin
      if (sda_f_ff)
        state_ff <= ST_IGNORE;
    end else if (scl_fall && bitcnt_ff == `GR_BIT_ACKCLK && state_ff == ST_RDATA) begin
      ptr_ff <= (ptr_ff >= `GR_LAST_CHAN) ? 4'h0 : ptr_ff + 4'h1;
    end
  end

  // The pin is only ever pulled low; the line floats high through the pull-up otherwise.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_low_ff <= 1'b0;
      tx_ff      <= 8'h00;
    end else if (start_seen || stop_seen) begin
      sda_low_ff <= 1'b0;
    end else if (byte_done) begin
      unique case (state_ff)
        ST_ADDR:         sda_low_ff <= (shift_ff[7:1] == {`GR_ADDR_HIGH, alsb_f_ff});
        ST_CTRL, ST_PTR: sda_low_ff <= 1'b1;
        ST_WDATA:        sda_low_ff <= push;
        default:         sda_low_ff <= 1'b0;
      endcase
    end else if (scl_fall && bitcnt_ff == `GR_BIT_ACKCLK) begin
      if (state_ff == ST_RDATA) begin
        tx_ff      <= bank_ff[rbank_ff][ptr_ff];
        sda_low_ff <= ~bank_ff[rbank_ff][ptr_ff][7];
      end else begin
        sda_low_ff <= 1'b0;
      end
    end else if (scl_fall && state_ff == ST_RDATA && bitcnt_ff < `GR_BIT_ACK) begin
      tx_ff      <= {tx_ff[6:0], 1'b0};
      sda_low_ff <= ~tx_ff[6];
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low_ff;

  // A full buffer refuses the byte with a not-acknowledge, so no code is ever dropped.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      buf_wr_ff  <= 1'b0;
      buf_rd_ff  <= 1'b0;
      buf_cnt_ff <= 2'h0;
      buf_ff[0]  <= 13'h0000;
      buf_ff[1]  <= 13'h0000;
    end else if (clk_en) begin
      if (push) begin
        buf_ff[buf_wr_ff] <= {wbank_ff, ptr_ff, shift_ff};
        buf_wr_ff         <= ~buf_wr_ff;
      end
      if (pop)
        buf_rd_ff <= ~buf_rd_ff;
      buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  assign buf_head = buf_ff[buf_rd_ff];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int b = 0; b < 2; b++)
        for (int c = 0; c < `GR_CHANNELS; c++)
          bank_ff[b][c] <= 8'h00;
    end else if (pop) begin
      bank_ff[buf_head[12]][buf_head[11:8]] <= buf_head[7:0];
    end
  end

  // Switching curves only reselects the source, so neither bank is disturbed.
  for (genvar ch = 0; ch < `GR_CHANNELS; ch++) begin : g_chan
    always_ff @(posedge core_clk) begin
      if (rst)
        code_ff[ch] <= 8'h00;
      else if (clk_en)
        code_ff[ch] <= bank_ff[csel_f_ff][ch];
    end
    if (ch < `GR_HALF) begin : g_up
      assign upper_bank_outputs[ch*8 +: 8] = code_ff[ch];
    end else begin : g_lo
      assign lower_bank_outputs[(ch-`GR_HALF)*8 +: 8] = code_ff[ch];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      free_cnt_ff <= 5'h00;
      bus_free_ff <= 1'b1;
    end else if (start_seen) begin
      bus_free_ff <= 1'b0;
      free_cnt_ff <= 5'h00;
    end else if (clk_en && !bus_free_ff && state_ff == ST_IDLE) begin
      if (free_cnt_ff == 5'(`GR_BUS_FREE_CYC - 1))
        bus_free_ff <= 1'b1;
      else
        free_cnt_ff <= free_cnt_ff + 5'h01;
    end
  end

  assign bus_busy = ~bus_free_ff;
endmodule : gr_i2c_port
`default_nettype wire

//--- dv/gr_port_assertions.sv
// Pin-level assertions for the gamma reference serial port.
`timescale 1ns/100ps
`default_nettype none
module gr_port_assertions (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe_n,
  input wire logic                curve_select,
  input wire logic                load_ready,
  input wire gr_pkg::gr_half_type upper_bank_outputs,
  input wire gr_pkg::gr_half_type lower_bank_outputs,
  input wire logic                bus_busy
);
  import gr_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence start_s; scl_in && $past(scl_in) && $fell(sda_in); endsequence
  sequence stop_s; scl_in && $past(scl_in) && $rose(sda_in); endsequence
  // Eight quiet cycles cover the synchroniser delay on curve_select.
  sequence quiet_s; (load_ready && !bus_busy && $stable(curve_select)) [*8]; endsequence
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
  a_busy_start: assert property (start_s |-> ##[1:10] bus_busy)
    else $error("busy missing after start");
  a_busy_free: assert property (stop_s |-> ##[20:40] !bus_busy)
    else $error("busy stuck after stop");
  a_busy_hold: assert property (stop_s |-> bus_busy [*8])
    else $error("busy dropped too early");
  a_start_release: assert property (start_s |-> ##[1:8] sda_oe_n)
    else $error("data held after start");
  a_stop_release: assert property (stop_s |-> ##[1:8] sda_oe_n)
    else $error("data held after stop");
  a_drive_clk_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data driven while clock high");
  a_release_clk_low: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("data released while clock high");
  a_idle_quiet: assert property (!bus_busy |-> sda_oe_n)
    else $error("data driven on idle bus");
  a_banks_quiet: assert property (quiet_s |=> $stable(upper_bank_outputs)
    && $stable(lower_bank_outputs)) else $error("outputs moved without cause");
endmodule : gr_port_assertions
bind gr_i2c_port gr_port_assertions u_chk (.core_clk, .rst, .scl_in, .sda_in, .sda_out,
  .sda_oe_n, .curve_select, .load_ready, .upper_bank_outputs, .lower_bank_outputs, .bus_busy);
`default_nettype wire

//--- dv/gr_bus_master.sv
// Bus master model that clocks frames onto the two-wire port.
`timescale 1ns/100ps
`default_nettype none
module gr_bus_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // A 2.6 us bit keeps under the top rate, and every step lands on a core falling edge.
  task automatic start();
    sda_drv = 1'b1;
    #1300 scl = 1'b1;
    #1300 sda_drv = 1'b0;
    #1300 scl = 1'b0;
  endtask : start
  task automatic stop();
    #300 sda_drv = 1'b0;
    #1000 scl = 1'b1;
    #1300 sda_drv = 1'b1;
    #1300;
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    #300 sda_drv = b;
    #1000 scl = 1'b1;
    #650 r = sda;
    #650 scl = 1'b0;
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ack_in, ack);
  endtask : xfer
endmodule : gr_bus_master
`default_nettype wire

//--- dv/gr_i2c_port_tb.sv
// Self-checking bench for the gamma reference serial port.
`timescale 1ns/100ps
`default_nettype none
module gr_i2c_port_tb;
  import gr_pkg::*;
  logic        core_clk, rst, mode_strap_pin, address_lsb_strap, curve_select, load_ready;
  logic        scl, m_sda, sda_out, sda_oe_n, bus_busy, ack;
  logic [7:0]  q;
  gr_half_type up_o, lo_o;
  gr_code_type exp_bank [2][14];
  int          n_mismatch, n_tests;
  wire logic   sda = m_sda & (sda_oe_n | sda_out);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  gr_bus_master m (.scl(scl), .sda_drv(m_sda), .sda(sda));
  gr_i2c_port dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mode_strap_pin(mode_strap_pin),
    .address_lsb_strap(address_lsb_strap), .curve_select(curve_select),
    .load_ready(load_ready), .upper_bank_outputs(up_o), .lower_bank_outputs(lo_o),
    .bus_busy(bus_busy));
  function automatic gr_half_type pack(input int b, input int base);
    gr_half_type h;
    for (int i = 0; i < 7; i++) begin
      h[i*8 +: 8] = exp_bank[b][base+i];
    end
    return h;
  endfunction : pack
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic outs(input int b);
    chk(up_o, pack(b, 0));
    chk(lo_o, pack(b, 7));
  endtask : outs
  task automatic idle();
    int k;
    k = 0;
    while (bus_busy !== 1'b0 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 200) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (8) @(negedge core_clk);
  endtask : idle
  task automatic wr(input logic [7:0] ctrl, input int ptr, input int n, input int nack_at);
    logic [7:0] d;
    int         ch;
    ch = mode_strap_pin ? 0 : ptr;
    m.start();
    m.xfer({7'h74 | address_lsb_strap, 1'b0}, 1'b1, q, ack);
    chk(ack, 1'b0);
    m.xfer(ctrl, 1'b1, q, ack);
    chk(ack, 1'b0);
    if (!mode_strap_pin) begin
      m.xfer(8'(ptr), 1'b1, q, ack);
      chk(ack, 1'b0);
    end
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      m.xfer(d, 1'b1, q, ack);
      chk(ack, i >= nack_at);
      if (i < nack_at) exp_bank[ctrl[1]][ch+i] = d;
    end
    m.stop();
    idle();
  endtask : wr
  task automatic rd(input int b, input int first);
    m.start();
    m.xfer({7'h74 | address_lsb_strap, 1'b1}, 1'b1, q, ack);
    chk(ack, 1'b0);
    for (int i = 0; i < 14; i++) begin
      m.xfer(8'hff, i == 13, q, ack);
      chk(q, exp_bank[b][(first+i)%14]);
    end
    m.stop();
    idle();
  endtask : rd
  initial begin
    rst = 1'b1;
    mode_strap_pin = 1'b1;
    address_lsb_strap = 1'b0;
    curve_select = 1'b0;
    load_ready = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    foreach (exp_bank[i, j]) exp_bank[i][j] = 8'h00;
    void'($urandom(32'h5961));
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(sda_oe_n, 1'b1);
    chk(bus_busy, 1'b0);
    outs(0);
    address_lsb_strap = 1'($urandom);
    // Fifteen bytes per frame: the one past the last channel must be refused.
    for (int c = 0; c < 2; c++) begin
      wr({5'h0, 1'(c), 1'(c), 1'b0}, 0, 15, 14);
      outs(0);
      rd(c, 0);
    end
    curve_select = 1'b1;
    repeat (10) @(negedge core_clk);
    outs(1);
    m.start();
    m.xfer({6'h3a, ~address_lsb_strap, 1'b0}, 1'b1, q, ack);
    chk(ack, 1'b1);
    m.stop();
    idle();
    // Loads held off, so the third byte finds the buffer full.
    mode_strap_pin = 1'b0;
    load_ready = 1'b0;
    wr(8'h02, 2, 3, 2);
    load_ready = 1'b1;
    repeat (10) @(negedge core_clk);
    outs(1);
    // Register mode reads resume at the pointer the last write frame left, here channel 4.
    rd(0, 4);
    tally_and_finish();
  end
endmodule : gr_i2c_port_tb
`default_nettype wire
